// ==== src/imuss_device.sv ====
/*
 * imuss_device: sensor end of the sample stream. Decodes three-byte
 * write commands, holds the output configuration, and sends sample frames
 * automatically or on a burst request after data ready.
 * Assumes the host keeps command order; sample data arrives as plain
 * words on user ports, one 32-bit value per field.
 */
`timescale 1ns/10ps
`default_nettype none
module imuss_device (
	input wire logic rst,
	input wire logic clk_en,
	imuss_if.device link,
	input wire logic [31:0] sample_word [imuss_pkg::NUM_FIELDS],
	output logic sampling,
	output logic [7:0] out_sel_lo,
	output logic [7:0] out_sel_hi,
	output logic [7:0] out_width
);
	// ********************************************************
	// command receive
	// ********************************************************
	logic [7:0] cmd;
	logic [7:0] dat;
	logic [1:0] rx_idx;
	logic page;
	logic auto_mode;
	logic cmd_done;
	logic burst_req;
	logic [7:0] tx_b;
	logic tx_v;
	logic rdy;

	always_ff @(posedge link.mclk)
	begin
		if (rst)
		begin
			rx_idx <= 2'h0;
			cmd <= 8'h00;
			dat <= 8'h00;
		end
		else if (clk_en && link.tx_valid)
		begin
			// three bytes: command, one data byte, terminator
			unique case (rx_idx)
				2'h0:
				begin
					cmd <= link.tx_byte;
					rx_idx <= 2'h1;
				end
				2'h1:
				begin
					dat <= link.tx_byte;
					rx_idx <= 2'h2;
				end
				default:
					rx_idx <= 2'h0;
			endcase
		end
	end

	// a frame whose third byte is not the terminator is dropped
	assign cmd_done = clk_en && link.tx_valid && rx_idx == 2'h2
		&& link.tx_byte == imuss_pkg::TERM_BYTE;
	assign burst_req = cmd_done && cmd == imuss_pkg::HDR_BYTE
		&& dat == imuss_pkg::BURST_DATA;

	// ********************************************************
	// configuration and mode
	// ********************************************************
	always_ff @(posedge link.mclk)
	begin
		if (rst)
		begin
			page <= 1'b0;
			auto_mode <= 1'b0;
			out_sel_lo <= imuss_pkg::SEL_RESET;
			out_sel_hi <= imuss_pkg::SEL_RESET;
			out_width <= imuss_pkg::WIDTH_RESET;
			sampling <= 1'b0;
		end
		else if (cmd_done)
		begin
			if (cmd == imuss_pkg::CMD_PAGE)
				page <= dat[0];
			else if (page && !sampling)
			begin
				// output settings live on page one only
				if (cmd == imuss_pkg::CMD_OUT_SEL_LO)
					out_sel_lo <= dat;
				if (cmd == imuss_pkg::CMD_OUT_SEL_HI)
					out_sel_hi <= dat;
				if (cmd == imuss_pkg::CMD_OUT_WIDTH)
					out_width <= dat;
				if (cmd == imuss_pkg::CMD_UART_CTRL)
					auto_mode <= dat[imuss_pkg::UART_AUTO_BIT];
			end
			else if (!page && cmd == imuss_pkg::CMD_MODE)
			begin
				if (dat == imuss_pkg::MODE_SAMPLE)
					sampling <= 1'b1;
				else if (dat == imuss_pkg::MODE_CONFIG)
					sampling <= 1'b0;
			end
		end
	end

	// ********************************************************
	// sample timing and data ready
	// ********************************************************
	logic [6:0] tick;
	logic sample_due;
	logic busy;
	assign sample_due = tick == 7'(imuss_pkg::SAMPLE_PERIOD - 1);

	always_ff @(posedge link.mclk)
	begin
		if (rst || !sampling)
			tick <= 7'h00;
		else if (clk_en)
			tick <= sample_due ? 7'h00 : 7'(tick + 7'h01);
	end

	always_ff @(posedge link.mclk)
	begin
		if (rst || !sampling)
			rdy <= 1'b0;
		else if (clk_en)
		begin
			// ready drops once a frame is taken, so one burst per sample
			if (sample_due)
				rdy <= 1'b1;
			else if (busy)
				rdy <= 1'b0;
		end
	end

	// ********************************************************
	// frame transmit
	// ********************************************************
	function automatic logic field_on(input logic [3:0] f,
		input logic [7:0] lo, input logic [7:0] hi);
		logic on;
		on = 1'b0;
		if (f == imuss_pkg::F_FLAG)
			on = hi[imuss_pkg::SEL_FLAG_BIT];
		else if (f == imuss_pkg::F_TEMP)
			on = hi[imuss_pkg::SEL_TEMP_BIT];
		else if (f <= 4'h4)
			on = hi[imuss_pkg::SEL_RATE_BIT];
		else if (f <= imuss_pkg::F_ACCEL_Z)
			on = hi[imuss_pkg::SEL_ACCEL_BIT];
		else if (f == imuss_pkg::F_GPIO)
			on = lo[imuss_pkg::SEL_GPIO_BIT];
		else if (f == imuss_pkg::F_COUNT)
			on = lo[imuss_pkg::SEL_COUNT_BIT];
		return on;
	endfunction

	function automatic logic field_wide(input logic [3:0] f,
		input logic [7:0] w);
		logic wide;
		wide = 1'b0;
		if (f >= imuss_pkg::F_TEMP && f <= imuss_pkg::F_ACCEL_Z)
			wide = w[imuss_pkg::WIDTH_TEMP_BIT];
		return wide;
	endfunction

	typedef enum logic [1:0] {
		IMUSS_IDLE = 2'b00,
		IMUSS_HDR = 2'b01,
		IMUSS_DATA = 2'b11,
		IMUSS_TERM = 2'b10
	} imuss_tx_t;
	imuss_tx_t st;
	logic [3:0] fld;
	logic [1:0] bsel;
	logic [31:0] cur;
	logic last_byte;
	assign busy = st != IMUSS_IDLE;
	assign cur = sample_word[fld];
	// two bytes per word, four for a wide field
	assign last_byte = bsel == (field_wide(fld, out_width) ? 2'h3 : 2'h1);

	always_ff @(posedge link.mclk)
	begin
		if (rst)
		begin
			st <= IMUSS_IDLE;
			fld <= 4'h0;
			bsel <= 2'h0;
			tx_b <= 8'h00;
			tx_v <= 1'b0;
		end
		else if (clk_en)
		begin
			tx_v <= 1'b0;
			unique case (st)
				IMUSS_IDLE:
				begin
					// auto sends each sample manual waits
					if (sampling && (auto_mode ? sample_due : rdy && burst_req))
						st <= IMUSS_HDR;
				end
				IMUSS_HDR:
				begin
					tx_b <= imuss_pkg::HDR_BYTE;
					tx_v <= 1'b1;
					fld <= 4'h0;
					bsel <= 2'h0;
					st <= IMUSS_DATA;
				end
				IMUSS_DATA:
				begin
					// disabled fields are skipped in fixed order
					if (!field_on(fld, out_sel_lo, out_sel_hi))
						bsel <= 2'h0;
					else
					begin
						tx_b <= cur[8'(5'd31 - {bsel, 3'd0}) -: 8];
						tx_v <= 1'b1;
						bsel <= 2'(bsel + 2'h1);
					end
					if (!field_on(fld, out_sel_lo, out_sel_hi) || last_byte)
					begin
						bsel <= 2'h0;
						if (fld == imuss_pkg::F_COUNT)
							st <= IMUSS_TERM;
						else
							fld <= 4'(fld + 4'h1);
					end
				end
				IMUSS_TERM:
				begin
					tx_b <= imuss_pkg::TERM_BYTE;
					tx_v <= 1'b1;
					st <= IMUSS_IDLE;
				end
			endcase
		end
	end

	assign link.rx_byte = tx_b;
	assign link.rx_valid = tx_v;
	assign link.data_ready = rdy;
endmodule
`default_nettype wire

// ==== include/imuss_pkg.sv ====
/*
 * imuss_pkg: shared constants for the sample-stream link between the host
 * controller end and the sensor end: command bytes, data values, frame
 * markers and word counts.
 * Assumes both ends compile this package first and refer to it by scope.
 */
package imuss_pkg;
	// ********************************************************
	// command and data bytes
	// ********************************************************
	localparam logic [7:0] CMD_PAGE = 8'hFE;
	localparam logic [7:0] CMD_MODE = 8'h83;
	localparam logic [7:0] CMD_UART_CTRL = 8'h88;
	localparam logic [7:0] CMD_OUT_SEL_LO = 8'h8C;
	localparam logic [7:0] CMD_OUT_SEL_HI = 8'h8D;
	localparam logic [7:0] CMD_OUT_WIDTH = 8'h8F;
	localparam logic [7:0] HDR_BYTE = 8'h80;
	localparam logic [7:0] BURST_DATA = 8'h00;
	localparam logic [7:0] TERM_BYTE = 8'h0D;
	localparam logic [7:0] MODE_SAMPLE = 8'h01;
	localparam logic [7:0] MODE_CONFIG = 8'h02;
	localparam logic [7:0] SEL_LO_VAL = 8'h06;
	localparam logic [7:0] SEL_HI_VAL = 8'hF0;
	localparam logic [7:0] WIDTH_16 = 8'h00;
	localparam logic [7:0] WIDTH_32 = 8'h70;
	localparam logic [7:0] PAGE_0 = 8'h00;
	localparam logic [7:0] PAGE_1 = 8'h01;
	localparam logic [7:0] AUTO_ON = 8'h01;
	localparam logic [7:0] AUTO_OFF = 8'h00;
	// ********************************************************
	// field positions
	// ********************************************************
	// select low byte: bit1 counter, bit2 general io, bit0 check value
	localparam int SEL_CHECK_BIT = 0;
	localparam int SEL_COUNT_BIT = 1;
	localparam int SEL_GPIO_BIT = 2;
	// select high byte: bit7 flag, bit6 temp, bit5 rate, bit4 accel
	localparam int SEL_FLAG_BIT = 7;
	localparam int SEL_TEMP_BIT = 6;
	localparam int SEL_RATE_BIT = 5;
	localparam int SEL_ACCEL_BIT = 4;
	localparam int UART_AUTO_BIT = 0;
	// width byte bit 6 alone selects 32-bit temp, rate and accel together
	localparam int WIDTH_TEMP_BIT = 6;
	// ********************************************************
	// frame layout: flag,temp,xr,yr,zr,xa,ya,za,gpio,count
	// ********************************************************
	localparam int NUM_FIELDS = 10;
	localparam int FIELD_W = 4;
	localparam logic [3:0] F_FLAG = 4'h0;
	localparam logic [3:0] F_TEMP = 4'h1;
	localparam logic [3:0] F_ACCEL_Z = 4'h7;
	localparam logic [3:0] F_GPIO = 4'h8;
	localparam logic [3:0] F_COUNT = 4'h9;
	localparam logic [7:0] SEL_RESET = 8'h00;
	localparam logic [7:0] WIDTH_RESET = 8'h00;
	// cycles between samples offered by the sensor end
	localparam int SAMPLE_PERIOD = 64;
endpackage

// ==== include/imuss_if.sv ====
/*
 * imuss_if: byte link between host controller and sensor end.
 * Assumes single clock mclk; each byte is a one-cycle valid strobe, which
 * stands in for the serial line with its framing left out.
 */
`timescale 1ns/10ps
`default_nettype none
interface imuss_if (
	input wire logic mclk
);
	logic [7:0] tx_byte;
	logic tx_valid;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic data_ready;
	modport host (
		input mclk,
		output tx_byte,
		output tx_valid,
		input rx_byte,
		input rx_valid,
		input data_ready
	);
	modport device (
		input mclk,
		input tx_byte,
		input tx_valid,
		output rx_byte,
		output rx_valid,
		output data_ready
	);
endinterface
`default_nettype wire

// ==== src/imuss_host.sv ====
/*
 * imuss_host: host controller end. On start it writes the output
 * configuration, enters sampling, collects frames byte by byte and on stop
 * returns the device to configuration mode.
 * Assumes power-on and filter setup are done before start is raised.
 */
`timescale 1ns/10ps
`default_nettype none
module imuss_host (
	input wire logic rst,
	input wire logic clk_en,
	imuss_if.host link,
	input wire logic start,
	input wire logic stop,
	input wire logic wide,
	input wire logic auto_mode,
	output logic [7:0] frame_byte,
	output logic frame_valid,
	output logic active
);
	localparam int NCMD = 9;
	logic [7:0] seq_cmd [NCMD];
	logic [7:0] seq_dat [NCMD];
	// page one for output settings, page zero to enter sampling
	assign seq_cmd = '{imuss_pkg::CMD_PAGE, imuss_pkg::CMD_UART_CTRL,
		imuss_pkg::CMD_OUT_SEL_LO, imuss_pkg::CMD_OUT_SEL_HI,
		imuss_pkg::CMD_OUT_WIDTH, imuss_pkg::CMD_PAGE,
		imuss_pkg::CMD_MODE, imuss_pkg::HDR_BYTE, imuss_pkg::CMD_MODE};
	assign seq_dat = '{imuss_pkg::PAGE_1,
		auto_mode ? imuss_pkg::AUTO_ON : imuss_pkg::AUTO_OFF,
		imuss_pkg::SEL_LO_VAL, imuss_pkg::SEL_HI_VAL,
		wide ? imuss_pkg::WIDTH_32 : imuss_pkg::WIDTH_16,
		imuss_pkg::PAGE_0, imuss_pkg::MODE_SAMPLE,
		imuss_pkg::BURST_DATA, imuss_pkg::MODE_CONFIG};

	logic [3:0] idx;
	logic [1:0] pos;
	logic sending;
	logic in_sample;
	logic [7:0] tb;
	logic tv;
	logic rdy_seen;

	always_ff @(posedge link.mclk)
	begin
		if (rst)
		begin
			idx <= 4'h0;
			pos <= 2'h0;
			sending <= 1'b0;
			in_sample <= 1'b0;
			tb <= 8'h00;
			tv <= 1'b0;
			active <= 1'b0;
		end
		else if (clk_en)
		begin
			tv <= 1'b0;
			if (sending)
			begin
				// command, one data byte, terminator
				tb <= pos == 2'h0 ? seq_cmd[idx] :
					pos == 2'h1 ? seq_dat[idx] : imuss_pkg::TERM_BYTE;
				tv <= 1'b1;
				pos <= pos == 2'h2 ? 2'h0 : 2'(pos + 2'h1);
				if (pos == 2'h2)
				begin
					sending <= 1'b0;
					if (idx < 4'h6)
						idx <= 4'(idx + 4'h1);
					else if (idx == 4'h6)
						in_sample <= 1'b1;
					else if (idx == 4'h8)
					begin
						in_sample <= 1'b0;
						active <= 1'b0;
					end
				end
			end
			else if (!active && start)
			begin
				// configure only once start says setup is done
				active <= 1'b1;
				idx <= 4'h0;
				sending <= 1'b1;
			end
			else if (active && !in_sample && idx < 4'h7)
				sending <= 1'b1;
			else if (in_sample && stop)
			begin
				idx <= 4'h8;
				sending <= 1'b1;
			end
			else if (in_sample && !auto_mode && rdy_seen)
			begin
				// one burst per data ready
				idx <= 4'h7;
				sending <= 1'b1;
			end
		end
	end

	// data ready synchronised as a pin input
	logic rdy_s1;
	logic rdy_s2;
	logic rdy_s3;
	always_ff @(posedge link.mclk)
	begin
		if (rst)
		begin
			rdy_s1 <= 1'b0;
			rdy_s2 <= 1'b0;
			rdy_s3 <= 1'b0;
		end
		else if (clk_en)
		begin
			rdy_s1 <= link.data_ready;
			rdy_s2 <= rdy_s1;
			rdy_s3 <= rdy_s2;
		end
	end
	// rising edge only, so a held ready never triggers a second burst
	assign rdy_seen = rdy_s2 && !rdy_s3 && !sending;

	always_ff @(posedge link.mclk)
	begin
		if (rst)
		begin
			frame_byte <= 8'h00;
			frame_valid <= 1'b0;
		end
		else if (clk_en)
		begin
			frame_byte <= link.rx_byte;
			frame_valid <= link.rx_valid;
		end
	end

	assign link.tx_byte = tb;
	assign link.tx_valid = tv;
endmodule
`default_nettype wire

// ==== tb/imuss_monitor.sv ====
/*
 * imuss_monitor: link checks between the host end and the sensor end.
 * Assumes field bytes never equal the header or the terminator value.
 */
`timescale 1ns/10ps
`default_nettype none
module imuss_monitor (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] tx_byte,
	input wire logic tx_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_valid,
	input wire logic data_ready
);
	logic [1:0] tx_cnt;
	logic [7:0] cmd;
	logic [7:0] dat;
	logic samp;
	logic page;
	logic in_frame;
	logic rdy_seen;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ********************************************************
	// decoded host commands
	// ********************************************************
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			tx_cnt <= 2'h0;
			samp <= 1'b0;
			page <= 1'b0;
		end
		else if (tx_valid)
		begin
			tx_cnt <= (tx_cnt == 2'h2) ? 2'h0 : tx_cnt + 2'h1;
			if (tx_cnt == 2'h0)
				cmd <= tx_byte;
			if (tx_cnt == 2'h1)
				dat <= tx_byte;
			if (tx_cnt == 2'h2 && cmd == imuss_pkg::CMD_MODE)
				samp <= (dat == imuss_pkg::MODE_SAMPLE);
			if (tx_cnt == 2'h2 && cmd == imuss_pkg::CMD_PAGE)
				page <= dat[0];
		end
	end
	// ********************************************************
	// frame and ready tracking
	// ********************************************************
	always_ff @(posedge mclk)
	begin
		if (rst)
			in_frame <= 1'b0;
		else if (rx_valid)
			in_frame <= (rx_byte != imuss_pkg::TERM_BYTE);
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
			rdy_seen <= 1'b0;
		else if ($rose(data_ready))
			rdy_seen <= 1'b1;
		else if (tx_valid && tx_cnt == 2'h0)
			rdy_seen <= 1'b0;
	end
	// ********************************************************
	// assertions
	// ********************************************************
	chk_header_first: assert property (
		rx_valid && !in_frame |-> rx_byte == imuss_pkg::HDR_BYTE)
		else $error("frame does not start with header");
	chk_frame_ends: assert property (
		$rose(in_frame) |-> ##[1:120] !in_frame)
		else $error("frame not terminated in time");
	chk_write_term: assert property (
		tx_valid && tx_cnt == 2'h2 |-> tx_byte == imuss_pkg::TERM_BYTE)
		else $error("command third byte not terminator");
	chk_burst_ready: assert property (
		tx_valid && tx_cnt == 2'h0 && tx_byte == imuss_pkg::HDR_BYTE
		|-> rdy_seen)
		else $error("burst without new data ready");
	chk_burst_zero: assert property (
		tx_valid && tx_cnt == 2'h1 && cmd == imuss_pkg::HDR_BYTE
		|-> tx_byte == imuss_pkg::BURST_DATA)
		else $error("burst data byte not zero");
	chk_burst_reply: assert property (
		tx_valid && tx_cnt == 2'h2 && cmd == imuss_pkg::HDR_BYTE
		|-> ##[1:4] rx_valid && rx_byte == imuss_pkg::HDR_BYTE)
		else $error("no reply header after burst");
	chk_frame_sampling: assert property (
		rx_valid && !in_frame |-> $past(samp, 2))
		else $error("frame started outside sampling");
	chk_mode_page0: assert property (
		tx_valid && tx_cnt == 2'h0 && tx_byte == imuss_pkg::CMD_MODE
		|-> !page)
		else $error("mode command sent on page one");
	cover property (rx_valid && !in_frame && !rdy_seen);
	cover property (tx_valid && tx_cnt == 2'h2 && cmd == imuss_pkg::HDR_BYTE);
	cover property ($fell(samp));
endmodule
`default_nettype wire

// ==== tb/imuss_sample_stream_test.sv ====
/*
 * imuss_sample_stream_test: host end against sensor end, plus a second
 * sensor end driven directly for command refusals.
 * Assumes one 250 MHz clock and the package compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module imuss_sample_stream_test;
	logic mclk;
	logic rst;
	logic start;
	logic stop;
	logic wide;
	logic auto_mode;
	logic [31:0] sample_word [imuss_pkg::NUM_FIELDS];
	logic sampling;
	logic s2;
	logic [7:0] out_sel_lo;
	logic [7:0] out_sel_hi;
	logic [7:0] out_width;
	logic [7:0] lo2;
	logic [7:0] hi2;
	logic [7:0] w2;
	logic [7:0] frame_byte;
	logic frame_valid;
	logic active;
	logic [7:0] q[$];
	logic [7:0] h[$];
	logic [7:0] e[$];
	int n_mismatch = 0;
	int checks = 0;
	imuss_if link (.mclk(mclk));
	imuss_if link2 (.mclk(mclk));
	imuss_device imuss_device_i (.rst(rst), .clk_en(1'b1), .link(link),
		.sample_word(sample_word), .sampling(sampling),
		.out_sel_lo(out_sel_lo), .out_sel_hi(out_sel_hi),
		.out_width(out_width));
	imuss_host imuss_host_i (.rst(rst), .clk_en(1'b1), .link(link),
		.start(start), .stop(stop), .wide(wide), .auto_mode(auto_mode),
		.frame_byte(frame_byte), .frame_valid(frame_valid),
		.active(active));
	imuss_device imuss_device_i2 (.rst(rst), .clk_en(1'b1), .link(link2),
		.sample_word(sample_word), .sampling(s2), .out_sel_lo(lo2),
		.out_sel_hi(hi2), .out_width(w2));
	imuss_monitor imuss_monitor_i (.mclk(mclk), .rst(rst),
		.tx_byte(link.tx_byte), .tx_valid(link.tx_valid),
		.rx_byte(link.rx_byte), .rx_valid(link.rx_valid),
		.data_ready(link.data_ready));
	// ********************************************************
	// clock, byte collection and tasks
	// ********************************************************
	initial
	begin
		mclk = 1'b0;
		forever
			#2 mclk = ~mclk;
	end
	always @(negedge mclk)
	begin
		if (link.rx_valid === 1'b1)
			q.push_back(link.rx_byte);
		if (frame_valid === 1'b1)
			h.push_back(frame_byte);
	end
	task automatic cycles(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic hang();
		n_mismatch++;
		print_verdict();
	endtask
	task automatic do_reset();
		rst = 1'b1;
		start = 1'b0;
		stop = 1'b0;
		cycles(4);
		rst = 1'b0;
		q = {};
		h = {};
	endtask
	// three bytes per write; bad turns the terminator wrong
	task automatic send(input logic [7:0] c, input logic [7:0] d,
		input logic bad);
		link2.tx_valid = 1'b1;
		link2.tx_byte = c;
		cycles(1);
		link2.tx_byte = d;
		cycles(1);
		link2.tx_byte = imuss_pkg::TERM_BYTE ^ {7'h0, bad};
		cycles(1);
		link2.tx_valid = 1'b0;
		link2.tx_byte = ~link2.tx_byte;
		cycles(1);
	endtask
	task automatic expect_frame(input logic w);
		e = {imuss_pkg::HDR_BYTE};
		for (int i = 0; i < imuss_pkg::NUM_FIELDS; i++)
			for (int b = 0; b < ((w && i > 0 && i < 8) ? 4 : 2); b++)
				e.push_back(8'(8'h11 * (b + 1) + i));
		e.push_back(imuss_pkg::TERM_BYTE);
	endtask
	task automatic check_frames();
		for (int k = 0; k < 4000 && h.size() < 2 * e.size(); k++)
			cycles(1);
		if (h.size() < 2 * e.size())
			hang();
		for (int i = 0; i < 2 * e.size(); i++)
		begin
			check("link", q[i], e[i % e.size()]);
			check("host", h[i], e[i % e.size()]);
		end
	endtask
	// ********************************************************
	// main sequence
	// ********************************************************
	initial
	begin
		rst = 1'b1;
		wide = 1'b0;
		auto_mode = 1'b1;
		link2.tx_valid = 1'b0;
		link2.tx_byte = 8'h00;
		for (int i = 0; i < imuss_pkg::NUM_FIELDS; i++)
			sample_word[i] = 32'h11223344 + 32'h01010101 * 32'(i);
		do_reset();
		check("active", {7'h0, active}, 8'h00);
		start = 1'b1;
		expect_frame(1'b0);
		check_frames();
		check("sel_lo", out_sel_lo, imuss_pkg::SEL_LO_VAL);
		check("sel_hi", out_sel_hi, imuss_pkg::SEL_HI_VAL);
		check("width", out_width, imuss_pkg::WIDTH_16);
		check("sampling", {7'h0, sampling}, 8'h01);
		// start dropped too, or the host would configure again
		start = 1'b0;
		stop = 1'b1;
		for (int k = 0; k < 2000 && sampling !== 1'b0; k++)
			cycles(1);
		if (sampling !== 1'b0)
			hang();
		cycles(100);
		q = {};
		cycles(200);
		check("idle_bytes", 8'(q.size()), 8'h00);
		check("active", {7'h0, active}, 8'h00);
		// reset after stop, then manual bursts with wide fields
		do_reset();
		wide = 1'b1;
		auto_mode = 1'b0;
		start = 1'b1;
		expect_frame(1'b1);
		check_frames();
		check("width", out_width, imuss_pkg::WIDTH_32);
		send(imuss_pkg::CMD_OUT_SEL_LO, imuss_pkg::SEL_LO_VAL, 1'b0);
		check("page0_lo", lo2, 8'h00);
		send(imuss_pkg::CMD_PAGE, imuss_pkg::PAGE_1, 1'b0);
		send(imuss_pkg::CMD_OUT_SEL_LO, imuss_pkg::SEL_LO_VAL, 1'b1);
		check("bad_term", lo2, 8'h00);
		send(imuss_pkg::CMD_OUT_SEL_LO, imuss_pkg::SEL_LO_VAL, 1'b0);
		check("lo2", lo2, imuss_pkg::SEL_LO_VAL);
		send(imuss_pkg::CMD_OUT_SEL_HI, imuss_pkg::SEL_HI_VAL, 1'b0);
		check("hi2", hi2, imuss_pkg::SEL_HI_VAL);
		send(imuss_pkg::CMD_OUT_WIDTH, imuss_pkg::WIDTH_32, 1'b0);
		check("w2", w2, imuss_pkg::WIDTH_32);
		send(imuss_pkg::CMD_MODE, imuss_pkg::MODE_SAMPLE, 1'b0);
		check("page1_mode", {7'h0, s2}, 8'h00);
		send(imuss_pkg::CMD_PAGE, imuss_pkg::PAGE_0, 1'b0);
		send(imuss_pkg::CMD_MODE, imuss_pkg::MODE_SAMPLE, 1'b0);
		check("s2_on", {7'h0, s2}, 8'h01);
		send(imuss_pkg::CMD_MODE, imuss_pkg::MODE_CONFIG, 1'b0);
		check("s2_off", {7'h0, s2}, 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
